// ===== rtl/hsrs_top.sv
// Purpose: run/stop control and top-level status of a high speed host controller
// Assumes: APB slave, 20 MHz core clock, synchronous active-high reset
// Notes: the transaction engine reports busy and memory read results as inputs
//
// How it works
// - schedules execute while run bit is set
// - clearing run finishes transaction, then stops
// - setting run clears stopped flag immediately
// - run/stopped pair encodes halting/halted/running/invalid
// - failed memory read clears the run bit
// - run bit resets to zero
// - command register write acts as command
// - writing one clears writable status bits
// - status holds no per-transaction results
// - status bits 31:16 read zero
// - bit 15 shows real asynchronous schedule state
// - asynchronous status follows enable with delay
// - bit 14 shows real periodic schedule state
// - status resets to 00001000h
// - stopped flag sets once execution ceased
// - asynchronous enable resets to zero, skip schedule
`timescale 1ns/1ps
module hsrs_top (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic rst_i,
    // apb slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // transaction engine
    input wire logic xact_busy_i,
    input wire logic mem_rd_done_i,
    input wire logic mem_rd_ok_i,
    output logic sched_run_o,
    output logic async_go_o,
    output logic periodic_go_o,
    // interrupt
    output logic irq_o
);
    import hsrs_pkg::*;

    // control registers
    logic run_control_bit_q; // run bit of host_command
    logic async_en_q; // asynchronous schedule enable
    logic periodic_en_q; // periodic schedule enable
    logic stopped_flag_q; // status bit 12
    logic syserr_q; // status bit 4, write one clears
    hsrs_state_t state_q;
    logic [HSRS_EV_W-1:0] evt_q; // sticky events
    logic [HSRS_EV_W-1:0] mask_q; // interrupt mask
    logic async_act; // real asynchronous schedule state
    logic periodic_act; // real periodic schedule state
    logic async_chg;
    logic periodic_chg;
    logic stop_evt; // pulse when halt completes
    logic err_evt; // failed memory read
    logic safe_pt; // between bus transactions

    // apb decode helpers
    logic wr_acc;
    logic rd_acc;
    logic [31:0] sts_val;

    // access phase; the slave always answers in the first access cycle
    assign wr_acc = psel_i && penable_i && pwrite_i;
    assign rd_acc = psel_i && penable_i && !pwrite_i;
    assign err_evt = mem_rd_done_i && !mem_rd_ok_i;
    assign safe_pt = !xact_busy_i;
    assign stop_evt = (state_q == HSRS_ST_HALTING) && !xact_busy_i;

    // address match used by every register
    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = (a == off);
    endfunction

    // assemble host_status; upper half reserved, no transaction results kept
    always_comb begin
        sts_val = '0;
        sts_val[HSRS_STS_ASY] = async_act;
        sts_val[HSRS_STS_PER] = periodic_act;
        sts_val[HSRS_STS_STOPPED] = stopped_flag_q;
        sts_val[HSRS_STS_SYSERR] = syserr_q;
    end

    // run bit: software writes act as commands, errors clear it
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            run_control_bit_q <= 1'b0;
            async_en_q <= 1'b0;
            periodic_en_q <= 1'b0;
        end else begin
            if (wr_acc && hit(paddr_i, HSRS_CMD_OFF)) begin
                run_control_bit_q <= pwdata_i[HSRS_CMD_RUN];
                async_en_q <= pwdata_i[HSRS_CMD_ASY_EN];
                periodic_en_q <= pwdata_i[HSRS_CMD_PER_EN];
            end
            // hardware clear wins so a faulty schedule never restarts silently
            if (err_evt) begin
                run_control_bit_q <= 1'b0;
            end
        end
    end

    // run state machine
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            state_q <= HSRS_ST_HALTED;
        end else begin
            case (state_q)
                HSRS_ST_HALTED: begin
                    if (run_control_bit_q) begin
                        state_q <= HSRS_ST_RUNNING;
                    end
                end
                HSRS_ST_RUNNING: begin
                    if (!run_control_bit_q) begin
                        state_q <= HSRS_ST_HALTING;
                    end
                end
                HSRS_ST_HALTING: begin
                    // let the current transaction end before stopping
                    if (!xact_busy_i) begin
                        state_q <= HSRS_ST_HALTED;
                    end
                end
                default: begin
                    state_q <= HSRS_ST_HALTED;
                end
            endcase
        end
    end

    // stopped flag; the run bit clears it in the same edge it is seen
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            stopped_flag_q <= HSRS_STS_RST[HSRS_STS_STOPPED];
        end else if (wr_acc && hit(paddr_i, HSRS_CMD_OFF) && pwdata_i[HSRS_CMD_RUN]
                && !err_evt) begin
            stopped_flag_q <= 1'b0;
        end else if (stop_evt && !run_control_bit_q) begin
            // a run bit set again while halting keeps the pair out of the invalid code
            stopped_flag_q <= 1'b1;
        end
    end

    // system error flag: hardware set beats software write-one-clear
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            syserr_q <= HSRS_STS_RST[HSRS_STS_SYSERR];
        end else if (err_evt) begin
            syserr_q <= 1'b1;
        end else if (wr_acc && hit(paddr_i, HSRS_STS_OFF) && pwdata_i[HSRS_STS_SYSERR]) begin
            syserr_q <= 1'b0;
        end
    end

    // engine outputs
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            sched_run_o <= 1'b0;
            async_go_o <= 1'b0;
            periodic_go_o <= 1'b0;
        end else begin
            sched_run_o <= (state_q == HSRS_ST_RUNNING) && run_control_bit_q;
            async_go_o <= async_act && run_control_bit_q;
            periodic_go_o <= periodic_act && run_control_bit_q;
        end
    end

    // schedule trackers
    hsrs_sched_track u_async (
        .core_clk_i(core_clk_i),
        .rst_i(rst_i),
        .enable_i(async_en_q),
        .safe_point_i(safe_pt),
        .active_o(async_act),
        .change_o(async_chg)
    );
    hsrs_sched_track u_periodic (
        .core_clk_i(core_clk_i),
        .rst_i(rst_i),
        .enable_i(periodic_en_q),
        .safe_point_i(safe_pt),
        .active_o(periodic_act),
        .change_o(periodic_chg)
    );

    // mask register
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            mask_q <= '0;
        end else if (wr_acc && hit(paddr_i, HSRS_MASK_OFF)) begin
            mask_q <= pwdata_i[HSRS_EV_W-1:0];
        end
    end

    // sticky events; a read clears them but a new event in that cycle survives
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            evt_q <= '0;
        end else begin
            // clear only what the setup cycle reported, so a later event is not lost
            if (rd_acc && hit(paddr_i, HSRS_EVT_OFF)) begin
                evt_q <= evt_q & ~prdata_o[HSRS_EV_W-1:0];
            end
            if (stop_evt) begin
                evt_q[HSRS_EV_STOP] <= 1'b1;
            end
            if (err_evt) begin
                evt_q[HSRS_EV_ERR] <= 1'b1;
            end
            if (async_chg || periodic_chg) begin
                evt_q[HSRS_EV_SCHED] <= 1'b1;
            end
        end
    end

    // interrupt level from registered sticky bits
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |(evt_q & mask_q);
        end
    end

    // apb read data and answer, zero wait states
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            prdata_o <= '0;
            pready_o <= 1'b0;
            pslverr_o <= 1'b0;
        end else begin
            pready_o <= psel_i && !penable_i;
            pslverr_o <= 1'b0;
            prdata_o <= '0;
            if (psel_i && !penable_i) begin
                pslverr_o <= !(hit(paddr_i, HSRS_CMD_OFF) || hit(paddr_i, HSRS_STS_OFF)
                    || hit(paddr_i, HSRS_MASK_OFF) || hit(paddr_i, HSRS_EVT_OFF));
                if (!pwrite_i) begin
                    case (paddr_i)
                        HSRS_CMD_OFF: begin
                            prdata_o <= {26'h0000000, async_en_q, periodic_en_q, 3'h0,
                                run_control_bit_q};
                        end
                        HSRS_STS_OFF: begin
                            prdata_o <= sts_val;
                        end
                        HSRS_MASK_OFF: begin
                            prdata_o <= {29'h00000000, mask_q};
                        end
                        HSRS_EVT_OFF: begin
                            prdata_o <= {29'h00000000, evt_q};
                        end
                        default: begin
                            prdata_o <= '0;
                        end
                    endcase
                end
            end
        end
    end

    // halting completes once the bus goes idle
    sequence s_halt_req;
        (state_q == HSRS_ST_RUNNING) && !run_control_bit_q;
    endsequence
    sequence s_halting_done;
        (state_q == HSRS_ST_HALTING) && !xact_busy_i && !run_control_bit_q;
    endsequence

    a_run_resets: assert property (@(posedge core_clk_i)
        $fell(rst_i) |-> !run_control_bit_q && stopped_flag_q)
        else $error("run bit or stopped flag wrong after reset");
    a_halt_seq: assert property (@(posedge core_clk_i) disable iff (rst_i)
        s_halt_req |=> (state_q == HSRS_ST_HALTING))
        else $error("run clear did not start halting");
    a_halt_flag: assert property (@(posedge core_clk_i) disable iff (rst_i)
        s_halting_done |=> stopped_flag_q)
        else $error("stopped flag not set after halt");
    a_run_stop_pair: assert property (@(posedge core_clk_i) disable iff (rst_i)
        run_control_bit_q |-> !stopped_flag_q)
        else $error("run and stopped both set");
    a_pair_halting: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (!run_control_bit_q && !stopped_flag_q) |-> (state_q != HSRS_ST_HALTED))
        else $error("halting pair without halting state");
    a_err_clears: assert property (@(posedge core_clk_i) disable iff (rst_i)
        err_evt |=> !run_control_bit_q && syserr_q)
        else $error("memory read error did not stop run");
    a_cmd_write: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (wr_acc && hit(paddr_i, HSRS_CMD_OFF) && !err_evt)
        |=> run_control_bit_q == $past(pwdata_i[HSRS_CMD_RUN]))
        else $error("command write did not take effect");
    a_w1c_clear: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (wr_acc && hit(paddr_i, HSRS_STS_OFF) && pwdata_i[HSRS_STS_SYSERR] && !err_evt)
        |=> !syserr_q)
        else $error("write one did not clear status bit");
    a_sts_upper: assert property (@(posedge core_clk_i) disable iff (rst_i)
        pready_o |-> (prdata_o[31:16] == 16'h0000))
        else $error("reserved status bits not zero");
    a_run_exec: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (state_q == HSRS_ST_RUNNING && run_control_bit_q) |=> sched_run_o)
        else $error("schedule not running while run set");
    a_sched_busy: assert property (@(posedge core_clk_i) disable iff (rst_i)
        xact_busy_i |=> $stable(async_act) && $stable(periodic_act))
        else $error("schedule status moved during a transaction");
endmodule

// ===== rtl/hsrs_pkg.sv
// Purpose: shared constants for the high speed host run/stop and status block
// Assumes: 32-bit APB register access, one core clock
// Notes: offsets are byte addresses
package hsrs_pkg;
    // register offsets
    localparam logic [7:0] HSRS_CMD_OFF = 8'h00; // host_command
    localparam logic [7:0] HSRS_STS_OFF = 8'h04; // host_status
    localparam logic [7:0] HSRS_MASK_OFF = 8'h08; // interrupt mask
    localparam logic [7:0] HSRS_EVT_OFF = 8'h0C; // sticky event status, read clears
    // host_command fields
    localparam int HSRS_CMD_RUN = 0;
    localparam int HSRS_CMD_PER_EN = 4;
    localparam int HSRS_CMD_ASY_EN = 5;
    // host_status fields
    localparam int HSRS_STS_SYSERR = 4;
    localparam int HSRS_STS_STOPPED = 12;
    localparam int HSRS_STS_PER = 14;
    localparam int HSRS_STS_ASY = 15;
    localparam logic [31:0] HSRS_STS_RST = 32'h00001000;
    // sticky event fields
    localparam int HSRS_EV_W = 3;
    localparam int HSRS_EV_STOP = 0;
    localparam int HSRS_EV_ERR = 1;
    localparam int HSRS_EV_SCHED = 2;
    // run state machine, one-hot
    typedef enum logic [2:0] {
        HSRS_ST_HALTED = 3'b001,
        HSRS_ST_RUNNING = 3'b010,
        HSRS_ST_HALTING = 3'b100
    } hsrs_state_t;
endpackage

// ===== rtl/hsrs_sched_track.sv
// Purpose: tracks the real state of one transfer schedule
// Assumes: enable is a register bit on the same clock
// Notes: follows enable only at a safe traversal point
`timescale 1ns/1ps
module hsrs_sched_track (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic rst_i,
    // control
    input wire logic enable_i,
    input wire logic safe_point_i,
    // status
    output logic active_o,
    output logic change_o
);
    import hsrs_pkg::*;

    // actual schedule state, disabled after reset
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            active_o <= 1'b0;
            change_o <= 1'b0;
        end else begin
            change_o <= 1'b0;
            // only move between transactions so a traversal is never cut
            if (safe_point_i && (active_o != enable_i)) begin
                active_o <= enable_i;
                change_o <= 1'b1;
            end
        end
    end

    // status agrees with enable within one cycle of a safe point
    a_sched_follow: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (safe_point_i && active_o != enable_i) |=> (active_o == $past(enable_i)))
        else $error("schedule status did not follow enable at safe point");
endmodule

// ===== test/hsrs_engine_model.sv
// Purpose: transaction engine stand-in on the far side of the run/stop block
// Assumes: one core clock, bench requests a transaction by a start pulse
// Notes: the result line carries a changing pattern outside the done pulse
`timescale 1ns/1ps
module hsrs_engine_model (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic rst_i,
    // bench requests
    input wire logic start_i,
    input wire logic bad_i,
    input wire logic [7:0] len_i,
    // engine outputs
    output logic xact_busy_o,
    output logic mem_rd_done_o,
    output logic mem_rd_ok_o
);
    logic [7:0] cnt_q; // cycles left in the transaction
    logic bad_q; // result of the read that ends it
    // busy for len cycles, then one read completion with its status
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            cnt_q <= 8'h00;
            bad_q <= 1'b0;
            xact_busy_o <= 1'b0;
            mem_rd_done_o <= 1'b0;
            mem_rd_ok_o <= 1'b0;
        end else begin
            mem_rd_done_o <= 1'b0;
            // outside done the status line is not meaningful, so keep it moving
            mem_rd_ok_o <= ~mem_rd_ok_o;
            if (start_i) begin
                cnt_q <= len_i;
                bad_q <= bad_i;
                xact_busy_o <= 1'b1;
            end else if (cnt_q != 8'h00) begin
                cnt_q <= cnt_q - 8'h01;
                if (cnt_q == 8'h01) begin
                    xact_busy_o <= 1'b0;
                    mem_rd_done_o <= 1'b1;
                    mem_rd_ok_o <= ~bad_q;
                end
            end
        end
    end
endmodule

// ===== test/tb.sv
// Purpose: self-checking bench of the run/stop and status block
// Assumes: zero wait state apb slave, engine model on the far side
// Notes: one idle cycle between apb transfers keeps each drive single per step
`timescale 1ns/1ps
module tb;
    import hsrs_pkg::*;
    logic clk = 1'b0; // core clock, 50 ns
    logic rst = 1'b1; // synchronous reset
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata_o;
    logic pready_o, pslverr_o, busy, done, ok, run_o, asy_o, per_o, irq_o;
    logic start = 1'b0, bad = 1'b0; // engine requests
    logic [7:0] len = 8'h00;
    logic [31:0] d; // read data scratch
    logic e; // slave error scratch
    int error_cnt = 0;
    int num_checks = 0;
    hsrs_top i_hsrs_top (.core_clk_i(clk), .rst_i(rst), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
        .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
        .xact_busy_i(busy), .mem_rd_done_i(done), .mem_rd_ok_i(ok),
        .sched_run_o(run_o), .async_go_o(asy_o), .periodic_go_o(per_o), .irq_o(irq_o));
    hsrs_engine_model i_hsrs_engine_model (.core_clk_i(clk), .rst_i(rst),
        .start_i(start), .bad_i(bad), .len_i(len), .xact_busy_o(busy),
        .mem_rd_done_o(done), .mem_rd_ok_o(ok));
    // free running clock
    initial begin
        forever #25 clk = ~clk;
    end
    task automatic give_verdict();
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // compare one value, four-state exact
    task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
        num_checks++;
        if (g !== x) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", nm, x, g);
        end
    endtask
    // one apb transfer; request held until pready is seen at an edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
        output logic [31:0] r, output logic er);
        int n;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready_o !== 1'b1 && n < 50);
        r = prdata_o;
        er = pslverr_o;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 50) begin
            chk("pready", 1, 0);
            give_verdict();
        end
        @(posedge clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] wd);
        logic [31:0] r;
        logic er;
        apb(1'b1, a, wd, r, er);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] r);
        logic er;
        apb(1'b0, a, 32'h00000000, r, er);
    endtask
    // launch an engine transaction of l cycles
    task automatic go(input logic [7:0] l, input logic b);
        start <= 1'b1;
        len <= l;
        bad <= b;
        @(posedge clk);
        start <= 1'b0;
        // let busy show before anyone waits for it to fall
        @(posedge clk);
    endtask
    // bounded wait for the engine to go idle, then let status settle
    task automatic wait_idle();
        int n;
        n = 0;
        while (busy !== 1'b0 && n < 300) begin
            @(posedge clk);
            n++;
        end
        if (n >= 300) begin
            chk("idle", 1, 0);
            give_verdict();
        end
        repeat (3) @(posedge clk);
    endtask
    task automatic t_reset();
        rd(HSRS_STS_OFF, d);
        chk("sts_rst", 32'h00001000, d);
        chk("run_rst", 0, run_o);
        chk("asy_rst", 0, asy_o);
    endtask
    task automatic t_run();
        wr(HSRS_CMD_OFF, 32'h00000001);
        rd(HSRS_STS_OFF, d);
        chk("sts_running", 32'h00000000, d);
        repeat (3) @(posedge clk);
        chk("sched_run", 1, run_o);
    endtask
    task automatic t_stop();
        go(8'd40, 1'b0);
        wr(HSRS_CMD_OFF, 32'h00000000);
        rd(HSRS_STS_OFF, d);
        chk("sts_halting", 32'h00000000, d);
        chk("busy_mid", 1, busy);
        wait_idle();
        rd(HSRS_STS_OFF, d);
        chk("sts_halted", 32'h00001000, d);
        rd(HSRS_EVT_OFF, d);
        chk("evt_halt", 32'h00000001, d & 32'h00000007);
        chk("irq_masked", 0, irq_o);
    endtask
    task automatic t_err();
        wr(HSRS_MASK_OFF, 32'h00000002);
        wr(HSRS_CMD_OFF, 32'h00000001);
        go(8'd4, 1'b1);
        wait_idle();
        chk("run_after_err", 0, run_o);
        rd(HSRS_STS_OFF, d);
        chk("sts_err", 32'h00001010, d);
        chk("irq_err", 1, irq_o);
        rd(HSRS_EVT_OFF, d);
        chk("evt_err", 32'h00000003, d & 32'h00000007);
        repeat (2) @(posedge clk);
        chk("irq_cleared", 0, irq_o);
        wr(HSRS_STS_OFF, 32'h00000000);
        rd(HSRS_STS_OFF, d);
        chk("sts_w0", 32'h00001010, d);
        wr(HSRS_STS_OFF, 32'h00001010);
        rd(HSRS_STS_OFF, d);
        chk("sts_w1", 32'h00001000, d);
    endtask
    task automatic t_sched();
        go(8'd40, 1'b0);
        wr(HSRS_CMD_OFF, 32'h00000031);
        rd(HSRS_STS_OFF, d);
        chk("sts_sched_busy", 32'h00000000, d);
        wait_idle();
        rd(HSRS_STS_OFF, d);
        chk("sts_sched_on", 32'h0000C000, d);
        chk("async_go", 1, asy_o);
        chk("periodic_go", 1, per_o);
        rd(HSRS_EVT_OFF, d);
        chk("evt_sched", 32'h00000004, d & 32'h00000007);
        wr(HSRS_CMD_OFF, 32'h00000000);
        repeat (3) @(posedge clk);
        rd(HSRS_STS_OFF, d);
        chk("sts_sched_off", 32'h00001000, d);
        wr(HSRS_CMD_OFF, 32'h00000000);
        wait_idle();
        rd(HSRS_STS_OFF, d);
        chk("sts_final", 32'h00001000, d);
    endtask
    task automatic t_unmapped();
        apb(1'b1, 8'h10, 32'h00000001, d, e);
        chk("err_wr", 1, e);
        apb(1'b0, 8'h10, 32'h00000000, d, e);
        chk("err_rd", 1, e);
        chk("err_data", 32'h00000000, d);
        repeat (3) @(posedge clk);
        chk("run_unmapped", 0, run_o);
    endtask
    // main sequence
    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_reset();
        t_run();
        t_stop();
        t_err();
        t_sched();
        t_unmapped();
        give_verdict();
    end
endmodule
